/* alu_unit.v */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_core_defines.vh"

module alu_unit (
  input wire [3:0] op_i,
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire [7:0] flags_i,
  output reg [7:0] result_o,
  output reg [7:0] flags_o
);
  reg cy;
  reg h;
  reg v;
  reg c;
  reg upd;

  // Single-cycle result and flag computation
  always @* begin
    cy = flags_i[`FLAG_C] & ((op_i == `ALU_ADC) | (op_i == `ALU_SBC));
    result_o = b_i;
    h = flags_i[`FLAG_H];
    v = flags_i[`FLAG_V];
    c = flags_i[`FLAG_C];
    upd = 1'b1;
    case (op_i)
      `ALU_ADD, `ALU_ADC: begin
        result_o = a_i + b_i + {7'h00, cy};
        h = (a_i[3] & b_i[3]) | (b_i[3] & ~result_o[3]) | (~result_o[3] & a_i[3]);
        c = (a_i[7] & b_i[7]) | (b_i[7] & ~result_o[7]) | (~result_o[7] & a_i[7]);
        v = (a_i[7] & b_i[7] & ~result_o[7]) | (~a_i[7] & ~b_i[7] & result_o[7]);
      end
      `ALU_SUB, `ALU_SBC: begin
        result_o = a_i - b_i - {7'h00, cy};
        h = (~a_i[3] & b_i[3]) | (b_i[3] & result_o[3]) | (result_o[3] & ~a_i[3]);
        c = (~a_i[7] & b_i[7]) | (b_i[7] & result_o[7]) | (result_o[7] & ~a_i[7]);
        v = (a_i[7] & ~b_i[7] & ~result_o[7]) | (~a_i[7] & b_i[7] & result_o[7]);
      end
      `ALU_AND: begin
        result_o = a_i & b_i;
        v = 1'b0;
      end
      `ALU_OR: begin
        result_o = a_i | b_i;
        v = 1'b0;
      end
      `ALU_EOR: begin
        result_o = a_i ^ b_i;
        v = 1'b0;
      end
      `ALU_INC: begin
        result_o = a_i + 8'h01;
        v = (result_o == 8'h80);
      end
      `ALU_DEC: begin
        result_o = a_i - 8'h01;
        v = (result_o == 8'h7f);
      end
      `ALU_LSR: begin
        result_o = {1'b0, a_i[7:1]};
        c = a_i[0];
        v = a_i[0]; // N is zero here, so V = N ^ C = C
      end
      default: upd = 1'b0; // Moves leave the flags alone
    endcase
    flags_o = flags_i;
    // Flags follow every ALU result except moves and unused codes, for later branches
    if (upd) begin
      flags_o[`FLAG_H] = h;
      flags_o[`FLAG_V] = v;
      flags_o[`FLAG_N] = result_o[7];
      flags_o[`FLAG_Z] = (result_o == 8'h00);
      flags_o[`FLAG_C] = c;
      flags_o[`FLAG_S] = result_o[7] ^ v;
    end
  end
endmodule // alu_unit
`default_nettype wire

/* core_flags_checker_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module core_flags_checker #(
  parameter IRQ_N = 8,
  parameter [15:0] BOOT_START = 16'h0c00,
  parameter [15:0] VEC_STEP = 16'h0002
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [15:0] pm_addr_o,
  input wire logic pm_wr_o,
  input wire logic [15:0] dm_addr_o,
  input wire logic dm_rd_o,
  input wire logic dm_wr_o,
  input wire logic [IRQ_N-1:0] irq_req_i,
  input wire logic irq_ack_o,
  input wire logic [4:0] irq_id_o,
  input wire logic [7:0] processor_status_flags_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Short alias keeps the flag properties readable
  wire [7:0] f = processor_status_flags_o;
  // Lowest pending index, since the lower vector wins
  function automatic [4:0] low_idx(input logic [IRQ_N-1:0] r);
    for (int k = 0; k < IRQ_N; k++) if (r[k]) return k[4:0];
    return 5'h00;
  endfunction
  // Return address leaves as two back-to-back writes, the second one address lower
  sequence push_s;
    dm_wr_o ##1 (dm_wr_o && dm_addr_o == $past(dm_addr_o) - 16'h0001);
  endsequence
  // Fetch lands on the vector of the granted request one cycle after the grant
  sequence vector_s;
    ##1 pm_addr_o == ({11'h000, irq_id_o} + 16'h0001) * VEC_STEP;
  endsequence
  sign_xor_a: assert property (f[4] == (f[2] ^ f[3]))
    else $error("sign flag differs from negative xor overflow");
  reset_clean_a: assert property ($fell(reset_i) |-> f == 8'h00 && pm_addr_o == 16'h0000)
    else $error("flags or fetch address not cleared by reset");
  // Fetch address runs one word ahead of the store that raised the strobe
  boot_only_a: assert property (pm_wr_o |-> $past(pm_addr_o) > BOOT_START)
    else $error("program write from outside the boot section");
  ext_window_a: assert property ((dm_rd_o || dm_wr_o) |-> dm_addr_o >= 16'h0060)
    else $error("data bus access below the extended window");
  gate_off_a: assert property (irq_ack_o |-> $past(f[7]) && $past(|irq_req_i))
    else $error("interrupt taken with global enable low");
  entry_clear_a: assert property (irq_ack_o |-> ##[0:1] !f[7])
    else $error("global enable still set after interrupt entry");
  ack_single_a: assert property (irq_ack_o |=> !irq_ack_o)
    else $error("second interrupt accepted right after entry");
  prio_pick_a: assert property (irq_ack_o |-> irq_id_o == low_idx($past(irq_req_i)))
    else $error("granted request is not the lowest pending index");
  vector_jump_a: assert property (irq_ack_o |-> vector_s)
    else $error("fetch did not move to the interrupt vector");
  stack_push_a: assert property (irq_ack_o |-> push_s)
    else $error("return address not pushed on interrupt entry");
endmodule // core_flags_checker
bind cpu_core_status_flags core_flags_checker #(.IRQ_N(IRQ_N), .BOOT_START(BOOT_START),
  .VEC_STEP(VEC_STEP)) chk_u (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .pm_addr_o(pm_addr_o), .pm_wr_o(pm_wr_o), .dm_addr_o(dm_addr_o), .dm_rd_o(dm_rd_o),
  .dm_wr_o(dm_wr_o), .irq_req_i(irq_req_i), .irq_ack_o(irq_ack_o), .irq_id_o(irq_id_o),
  .processor_status_flags_o(processor_status_flags_o));
`default_nettype wire

/* cpu_core_defines.vh */
`ifndef CPU_CORE_DEFINES_VH
`define CPU_CORE_DEFINES_VH

// Status flag bit positions
`define FLAG_I 7
`define FLAG_T 6
`define FLAG_H 5
`define FLAG_S 4
`define FLAG_V 3
`define FLAG_N 2
`define FLAG_Z 1
`define FLAG_C 0
`define FLAGS_RESET 8'h00

// I/O indexes of core-owned registers
`define IO_SPL 6'h3d
`define IO_SPH 6'h3e
`define IO_STATUS 6'h3f

// Data space windows
`define DS_IO_BASE 16'h0020
`define DS_EXT_BASE 16'h0060

// Major opcodes, instruction bits 15:12
`define OP_MISC 4'h0
`define OP_ARITH 4'h1
`define OP_LOGIC 4'h2
`define OP_SUBI 4'h3
`define OP_ANDI 4'h4
`define OP_LDI 4'h5
`define OP_UNARY 4'h6
`define OP_BIT 4'h7
`define OP_LDST 4'h8
`define OP_LDS 4'h9
`define OP_INOUT 4'ha
`define OP_RJMP 4'hb
`define OP_RCALL 4'hc
`define OP_BRANCH 4'hd

// Misc sub-codes, instruction bits 11:8
`define MISC_NOP 4'h0
`define MISC_GIE_SET 4'h1
`define MISC_GIE_CLR 4'h2
`define MISC_RET 4'h3
`define MISC_IRET 4'h4
`define MISC_PSTORE 4'h5
`define MISC_PLOAD 4'h6

// ALU operations
`define ALU_ADD 4'h0
`define ALU_ADC 4'h1
`define ALU_SUB 4'h2
`define ALU_SBC 4'h3
`define ALU_AND 4'h4
`define ALU_OR 4'h5
`define ALU_EOR 4'h6
`define ALU_MOV 4'h7
`define ALU_INC 4'h8
`define ALU_DEC 4'h9
`define ALU_LSR 4'ha

`endif

/* cpu_core_status_flags.v */
`timescale 1ns/100ps
`default_nettype none
`include "cpu_core_defines.vh"

module cpu_core_status_flags #(
  parameter IRQ_N = 8,
  parameter [15:0] BOOT_START = 16'h0c00,
  parameter [15:0] VEC_STEP = 16'h0002,
  parameter [15:0] STACK_RESET = 16'h02ff
) (
  input wire sys_clk_i,
  input wire reset_i,
  output reg [15:0] pm_addr_o,
  input wire [15:0] pm_data_i,
  output reg pm_wr_o,
  output reg [15:0] pm_wr_addr_o,
  output reg [15:0] pm_wr_data_o,
  output reg [15:0] dm_addr_o,
  output reg dm_rd_o,
  output reg dm_wr_o,
  output reg [7:0] dm_wr_data_o,
  input wire [7:0] dm_rd_data_i,
  output reg [5:0] io_addr_o,
  output reg io_rd_o,
  output reg io_wr_o,
  output reg [7:0] io_wr_data_o,
  input wire [7:0] io_rd_data_i,
  input wire [IRQ_N-1:0] irq_req_i,
  output reg irq_ack_o,
  output reg [4:0] irq_id_o,
  output reg [7:0] processor_status_flags_o
);
  localparam [2:0] S_RUN = 3'h0;
  localparam [2:0] S_LOAD = 3'h1;
  localparam [2:0] S_PUSH = 3'h2;
  localparam [2:0] S_POP_HI = 3'h3;
  localparam [2:0] S_POP_LO = 3'h4;
  localparam [2:0] S_PLOAD = 3'h5;

  reg [2:0] state;
  reg [15:0] ir;
  reg [15:0] ir_pc;
  reg ir_valid;
  reg [7:0] gpr [0:31];
  reg [15:0] sp;
  reg [15:0] ret_addr;
  reg [15:0] jmp_addr;
  reg [4:0] ld_dst;
  reg ld_from_io;
  reg iret_pend;
  reg [7:0] pop_hi;
  reg [3:0] alu_op;
  reg alu_wr;
  reg [4:0] irq_sel;
  integer i;
  integer j;

  // Fields of the instruction in execution
  wire [3:0] opc = ir[15:12];
  wire [3:0] misc = ir[11:8];
  wire imm_op = (opc == `OP_SUBI) | (opc == `OP_ANDI) | (opc == `OP_LDI);
  wire [4:0] alu_dst = imm_op ? {1'b1, ir[7:4]} : ir[9:5];
  wire [7:0] imm = {ir[11:8], ir[3:0]};
  wire [7:0] alu_b = imm_op ? imm : gpr[ir[4:0]];
  wire [7:0] alu_res;
  wire [7:0] alu_flags;

  // Pointer pair select; code 00 falls back to the 26/27 pair
  wire [1:0] ptr_sel = (ir[10:9] == 2'b00) ? 2'b01 : ir[10:9];
  wire [4:0] ptr_lo = {2'b11, ptr_sel, 1'b0};
  wire [15:0] ptr = {gpr[{ptr_lo[4:1], 1'b1}], gpr[ptr_lo]};
  wire [15:0] ptr_inc = ptr + 16'h0001;
  wire [15:0] z_ptr = {gpr[31], gpr[30]};

  // Data-space decode; the second word of a long load/store is on pm_data_i
  wire is_io_insn = (opc == `OP_INOUT);
  wire [15:0] ea = (opc == `OP_LDS) ? pm_data_i : ptr;
  wire [15:0] io_off = ea - `DS_IO_BASE;
  wire ea_reg = (ea < `DS_IO_BASE);
  wire ea_io = ~ea_reg & (ea < `DS_EXT_BASE);
  wire acc_reg = ~is_io_insn & ea_reg;
  wire acc_io = is_io_insn | ea_io;
  // Direct I/O carries only six address bits, so 0x60 and up stay out of reach
  wire [5:0] io_idx = is_io_insn ? ir[10:5] : io_off[5:0];
  wire [4:0] mem_d = is_io_insn ? ir[4:0] : ir[8:4];
  wire [7:0] st_data = gpr[mem_d];
  wire int_hit = (io_idx == `IO_STATUS) | (io_idx == `IO_SPL) | (io_idx == `IO_SPH);
  wire [7:0] int_rd = (io_idx == `IO_STATUS) ? processor_status_flags_o :
                      (io_idx == `IO_SPL) ? sp[7:0] : sp[15:8];

  // Branch targets relative to the fetch address
  wire [15:0] rel_jmp = pm_addr_o + {{4{ir[11]}}, ir[11:0]};
  wire [15:0] rel_br = pm_addr_o + {{8{ir[7]}}, ir[7:0]};
  wire br_taken = (processor_status_flags_o[ir[10:8]] == ir[11]);
  wire [15:0] irq_vec = ({11'h000, irq_sel} + 16'h0001) * VEC_STEP;
  wire take_irq = ir_valid & processor_status_flags_o[`FLAG_I] & (|irq_req_i);
  wire in_boot = (ir_pc >= BOOT_START);

  // Keeps S tied to N and V whatever writes the flags
  function [7:0] fix_sign;
    input [7:0] f;
    begin
      fix_sign = f;
      fix_sign[`FLAG_S] = f[`FLAG_N] ^ f[`FLAG_V];
    end
  endfunction

  // Lowest request index has the lowest vector and wins
  always @* begin
    irq_sel = 5'h00;
    for (i = IRQ_N - 1; i >= 0; i = i - 1) begin
      if (irq_req_i[i]) begin
        irq_sel = i[4:0];
      end
    end
  end

  // ALU operation select
  always @* begin
    alu_op = `ALU_MOV;
    alu_wr = 1'b1;
    case (opc)
      `OP_ARITH: alu_op = {2'b00, ir[11:10]};
      `OP_LOGIC: alu_op = {2'b01, ir[11:10]};
      `OP_SUBI: alu_op = `ALU_SUB;
      `OP_ANDI: alu_op = `ALU_AND;
      `OP_LDI: alu_op = `ALU_MOV;
      `OP_UNARY: alu_op = `ALU_INC + {2'b00, ir[1:0]};
      default: alu_wr = 1'b0;
    endcase
  end

  alu_unit u_alu (
    .op_i(alu_op),
    .a_i(gpr[alu_dst]),
    .b_i(alu_b),
    .flags_i(processor_status_flags_o),
    .result_o(alu_res),
    .flags_o(alu_flags)
  );

  // Fetch, execute and multi-cycle sequences
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= S_RUN;
      pm_addr_o <= 16'h0000;
      ir <= 16'h0000;
      ir_pc <= 16'h0000;
      ir_valid <= 1'b0;
      sp <= STACK_RESET;
      ret_addr <= 16'h0000;
      jmp_addr <= 16'h0000;
      ld_dst <= 5'h00;
      ld_from_io <= 1'b0;
      iret_pend <= 1'b0;
      pop_hi <= 8'h00;
      pm_wr_o <= 1'b0;
      pm_wr_addr_o <= 16'h0000;
      pm_wr_data_o <= 16'h0000;
      dm_addr_o <= 16'h0000;
      dm_rd_o <= 1'b0;
      dm_wr_o <= 1'b0;
      dm_wr_data_o <= 8'h00;
      io_addr_o <= 6'h00;
      io_rd_o <= 1'b0;
      io_wr_o <= 1'b0;
      io_wr_data_o <= 8'h00;
      irq_ack_o <= 1'b0;
      irq_id_o <= 5'h00;
      processor_status_flags_o <= `FLAGS_RESET;
      // Own loop variable, so the priority scan keeps i to itself
      for (j = 0; j < 32; j = j + 1) begin
        gpr[j] <= 8'h00;
      end
    end else begin
      // Strobes drop each cycle unless raised again; push and pop hold dm_wr_o or dm_rd_o for two cycles
      pm_wr_o <= 1'b0;
      dm_rd_o <= 1'b0;
      dm_wr_o <= 1'b0;
      io_rd_o <= 1'b0;
      io_wr_o <= 1'b0;
      irq_ack_o <= 1'b0;
      case (state)
        S_RUN: begin
          // Prefetch the next word while ir executes
          ir <= pm_data_i;
          ir_pc <= pm_addr_o;
          ir_valid <= 1'b1;
          pm_addr_o <= pm_addr_o + 16'h0001;
          if (take_irq) begin
            // Interrupted instruction is re-run after return
            ret_addr <= ir_pc;
            jmp_addr <= irq_vec;
            dm_addr_o <= sp;
            dm_wr_data_o <= ir_pc[7:0];
            dm_wr_o <= 1'b1;
            sp <= sp - 16'h0001;
            processor_status_flags_o[`FLAG_I] <= 1'b0;
            irq_ack_o <= 1'b1;
            irq_id_o <= irq_sel;
            ir_valid <= 1'b0;
            state <= S_PUSH;
          end else if (ir_valid) begin
            if (alu_wr) begin
              gpr[alu_dst] <= alu_res;
              processor_status_flags_o <= alu_flags;
            end
            case (opc)
              `OP_MISC: begin
                case (misc)
                  `MISC_GIE_SET: processor_status_flags_o[`FLAG_I] <= 1'b1;
                  `MISC_GIE_CLR: processor_status_flags_o[`FLAG_I] <= 1'b0;
                  `MISC_RET, `MISC_IRET: begin
                    iret_pend <= (misc == `MISC_IRET);
                    dm_addr_o <= sp + 16'h0001;
                    dm_rd_o <= 1'b1;
                    sp <= sp + 16'h0001;
                    ir_valid <= 1'b0;
                    state <= S_POP_HI;
                  end
                  `MISC_PSTORE: begin
                    // Ignored unless the instruction sits in the boot section
                    pm_wr_o <= in_boot;
                    pm_wr_addr_o <= z_ptr;
                    pm_wr_data_o <= {gpr[1], gpr[0]};
                  end
                  `MISC_PLOAD: begin
                    ret_addr <= pm_addr_o;
                    pm_addr_o <= {1'b0, z_ptr[15:1]};
                    ir_valid <= 1'b0;
                    state <= S_PLOAD;
                  end
                  default: ;
                endcase
              end
              `OP_BIT: begin
                if (ir[9]) begin
                  gpr[ir[8:4]][ir[2:0]] <= processor_status_flags_o[`FLAG_T];
                end else begin
                  processor_status_flags_o[`FLAG_T] <= gpr[ir[8:4]][ir[2:0]];
                end
              end
              `OP_LDST, `OP_LDS, `OP_INOUT: begin
                if (opc == `OP_LDS) begin
                  ir_valid <= 1'b0; // Address word is not an instruction
                end
                if (opc == `OP_LDST && ir[0]) begin
                  gpr[ptr_lo] <= ptr_inc[7:0];
                  gpr[{ptr_lo[4:1], 1'b1}] <= ptr_inc[15:8];
                end
                if (ir[11]) begin
                  if (acc_reg) begin
                    gpr[ea[4:0]] <= st_data;
                  end else if (acc_io && int_hit) begin
                    if (io_idx == `IO_STATUS) begin
                      processor_status_flags_o <= fix_sign(st_data);
                    end else if (io_idx == `IO_SPL) begin
                      sp[7:0] <= st_data;
                    end else begin
                      sp[15:8] <= st_data;
                    end
                  end else if (acc_io) begin
                    io_addr_o <= io_idx;
                    io_wr_data_o <= st_data;
                    io_wr_o <= 1'b1;
                  end else begin
                    dm_addr_o <= ea;
                    dm_wr_data_o <= st_data;
                    dm_wr_o <= 1'b1;
                  end
                end else begin
                  if (acc_reg) begin
                    gpr[mem_d] <= gpr[ea[4:0]];
                  end else if (acc_io && int_hit) begin
                    gpr[mem_d] <= int_rd;
                  end else begin
                    // External reads return next cycle; the prefetch already stands
                    io_addr_o <= io_idx;
                    io_rd_o <= acc_io;
                    dm_addr_o <= ea;
                    dm_rd_o <= ~acc_io;
                    ld_dst <= mem_d;
                    ld_from_io <= acc_io;
                    state <= S_LOAD;
                  end
                end
              end
              `OP_RJMP: begin
                pm_addr_o <= rel_jmp;
                ir_valid <= 1'b0;
              end
              `OP_RCALL: begin
                ret_addr <= pm_addr_o;
                jmp_addr <= rel_jmp;
                dm_addr_o <= sp;
                dm_wr_data_o <= pm_addr_o[7:0];
                dm_wr_o <= 1'b1;
                sp <= sp - 16'h0001;
                ir_valid <= 1'b0;
                state <= S_PUSH;
              end
              `OP_BRANCH: begin
                if (br_taken) begin
                  pm_addr_o <= rel_br;
                  ir_valid <= 1'b0;
                end
              end
              default: ;
            endcase
          end
        end
        S_LOAD: begin
          gpr[ld_dst] <= ld_from_io ? io_rd_data_i : dm_rd_data_i;
          state <= S_RUN;
        end
        S_PUSH: begin
          dm_addr_o <= sp;
          dm_wr_data_o <= ret_addr[15:8];
          dm_wr_o <= 1'b1;
          sp <= sp - 16'h0001;
          pm_addr_o <= jmp_addr;
          ir_valid <= 1'b0;
          state <= S_RUN;
        end
        S_POP_HI: begin
          pop_hi <= dm_rd_data_i;
          dm_addr_o <= sp + 16'h0001;
          dm_rd_o <= 1'b1;
          sp <= sp + 16'h0001;
          state <= S_POP_LO;
        end
        S_POP_LO: begin
          pm_addr_o <= {pop_hi, dm_rd_data_i};
          if (iret_pend) begin
            processor_status_flags_o[`FLAG_I] <= 1'b1;
          end
          ir_valid <= 1'b0;
          state <= S_RUN;
        end
        S_PLOAD: begin
          gpr[0] <= gpr[30][0] ? pm_data_i[15:8] : pm_data_i[7:0];
          pm_addr_o <= ret_addr;
          ir_valid <= 1'b0;
          state <= S_RUN;
        end
        default: state <= S_RUN;
      endcase
    end
  end
endmodule // cpu_core_status_flags
`default_nettype wire

/* prog_data_model.sv */
`timescale 1ns/100ps
`default_nettype none
module prog_data_model (
  input wire logic sys_clk_i,
  input wire logic [15:0] pm_addr_i,
  output logic [15:0] pm_data_o,
  input wire logic pm_wr_i,
  input wire logic [15:0] pm_wa_i,
  input wire logic [15:0] pm_wd_i,
  input wire logic [15:0] dm_addr_i,
  input wire logic dm_rd_i,
  input wire logic dm_wr_i,
  input wire logic [7:0] dm_wd_i,
  output logic [7:0] dm_rdat_o,
  input wire logic [5:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wd_i,
  output logic [7:0] io_rdat_o
);
  logic [15:0] prog [0:255];
  logic [7:0] dmem [0:1023];
  logic [7:0] iomem [0:63];
  logic [7:0] noise = 8'h5a;
  logic [15:0] pw_addr = 16'h0000;
  logic [15:0] pw_data = 16'h0000;
  int pw_cnt = 0;
  // Word is ready in the same cycle so fetch overlaps execute
  assign pm_data_o = prog[pm_addr_i[7:0]];
  // Unselected read lines carry a moving pattern, never the last value
  assign dm_rdat_o = dm_rd_i ? dmem[dm_addr_i[9:0]] : noise;
  assign io_rdat_o = io_rd_i ? iomem[io_addr_i] : ~noise;
  // Writes land at the edge that ends the strobe cycle
  always @(posedge sys_clk_i) begin
    noise <= {noise[6:0], noise[7] ^ noise[5] ^ 1'b1};
    if (pm_wr_i) begin
      prog[pm_wa_i[7:0]] <= pm_wd_i;
      pw_addr <= pm_wa_i;
      pw_data <= pm_wd_i;
      pw_cnt <= pw_cnt + 1;
    end
    if (dm_wr_i) dmem[dm_addr_i[9:0]] <= dm_wd_i;
    if (io_wr_i) iomem[io_addr_i] <= io_wd_i;
  end
endmodule // prog_data_model
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] irq_req_i = 8'h00;
  wire [15:0] pm_addr, pm_data, pm_wa, pm_wd, dm_addr;
  wire pm_wr, dm_rd, dm_wr, io_rd, io_wr, irq_ack;
  wire [7:0] dm_wd, dm_rdat, io_wd, io_rdat, flags;
  wire [5:0] io_addr;
  wire [4:0] irq_id;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int ack_cnt = 0;
  localparam int LIMIT = 3000;
  always #10 sys_clk_i = ~sys_clk_i;
  // Small boot section start keeps the program image short
  cpu_core_status_flags #(.BOOT_START(16'h0040)) dut_u (.sys_clk_i(sys_clk_i),
    .reset_i(reset_i), .pm_addr_o(pm_addr), .pm_data_i(pm_data), .pm_wr_o(pm_wr),
    .pm_wr_addr_o(pm_wa), .pm_wr_data_o(pm_wd), .dm_addr_o(dm_addr), .dm_rd_o(dm_rd),
    .dm_wr_o(dm_wr), .dm_wr_data_o(dm_wd), .dm_rd_data_i(dm_rdat), .io_addr_o(io_addr),
    .io_rd_o(io_rd), .io_wr_o(io_wr), .io_wr_data_o(io_wd), .io_rd_data_i(io_rdat),
    .irq_req_i(irq_req_i), .irq_ack_o(irq_ack), .irq_id_o(irq_id),
    .processor_status_flags_o(flags));
  prog_data_model mdl_u (.sys_clk_i(sys_clk_i), .pm_addr_i(pm_addr), .pm_data_o(pm_data),
    .pm_wr_i(pm_wr), .pm_wa_i(pm_wa), .pm_wd_i(pm_wd), .dm_addr_i(dm_addr), .dm_rd_i(dm_rd),
    .dm_wr_i(dm_wr), .dm_wd_i(dm_wd), .dm_rdat_o(dm_rdat), .io_addr_i(io_addr),
    .io_rd_i(io_rd), .io_wr_i(io_wr), .io_wd_i(io_wd), .io_rdat_o(io_rdat));
  // Cycle count cuts a hang short; acknowledges are tallied here
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (irq_ack === 1'b1) ack_cnt <= ack_cnt + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("mismatch at %0t: run too long", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic put(input int a, input logic [15:0] w);
    mdl_u.prog[a] = w;
  endtask
  // Reset held while the image is loaded; empty words act as no-ops
  task automatic setup;
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    irq_req_i <= 8'h00;
    ack_cnt = 0;
    mdl_u.pw_cnt = 0;
    for (int i = 0; i < 256; i++) put(i, 16'h0000);
    mdl_u.dmem[16'h161] = 8'h3c;
    mdl_u.iomem[1] = 8'hee;
  endtask
  // Release reset, then wait for fetch to reach address pc, then four cycles more
  task automatic go(input logic [15:0] pc);
    int n;
    repeat (5) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    n = 0;
    while (pm_addr !== pc && n < 60) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n == 60) chk(16'h0000, 16'h0001);
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic t_alu(input logic [3:0] op, input logic [1:0] sb,
                       input logic [7:0] a, b, res, fl);
    setup();
    put(0, {4'h5, a[7:4], 4'h0, a[3:0]});
    put(1, {4'h5, b[7:4], 4'h1, b[3:0]});
    put(2, {op, sb, 5'd16, 5'd17});
    put(3, 16'ha830);
    put(4, 16'hbfff);
    go(16'h0005);
    chk(mdl_u.iomem[1], res);
    chk(flags, fl);
    $display("alu case %h %h done", a, b);
  endtask
  task automatic t_bit;
    setup();
    put(0, 16'h5008);
    put(1, 16'h7103);
    put(2, 16'h7315);
    put(3, 16'ha831);
    put(4, 16'hbfff);
    go(16'h0005);
    chk(mdl_u.iomem[1], 16'h0020);
    chk(flags, 16'h0040);
    $display("bit copy test done");
  endtask
  // Long store's address word would set global enable if executed
  task automatic t_ldst;
    setup();
    put(0, 16'h56a0);
    put(1, 16'h50b1);
    put(2, 16'h5a05);
    put(3, 16'h8b01);
    put(4, 16'h8310);
    put(5, 16'ha831);
    put(6, 16'h9900);
    put(7, 16'h0100);
    put(8, 16'hbfff);
    go(16'h0009);
    chk(mdl_u.dmem[16'h160], 16'h00a5);
    chk(mdl_u.iomem[1], 16'h003c);
    chk(mdl_u.dmem[16'h100], 16'h00a5);
    chk(flags, 16'h0000);
    $display("load store test done");
  endtask
  task automatic t_pstore;
    setup();
    put(0, 16'h58e1);
    put(1, 16'h50f0);
    put(2, 16'h0600);
    put(3, 16'ha820);
    put(4, 16'h0500);
    put(5, 16'hb03a);
    put(16'h40, 16'h0500);
    put(16'h41, 16'hbfff);
    go(16'h0042);
    chk(mdl_u.iomem[1], 16'h0005);
    chk(mdl_u.pw_cnt, 16'h0001);
    chk(mdl_u.pw_addr, 16'h0081);
    chk(mdl_u.pw_data, 16'h0005);
    $display("program store test done");
  endtask
  // Handler saves and restores the flags, then returns; the request stays high
  // Enable is set only well after the first check, so that check sees no grant
  task automatic t_irq;
    setup();
    @(posedge sys_clk_i);
    irq_req_i <= 8'h06;
    put(0, 16'hb00f);
    put(4, 16'ha7f0);
    put(5, 16'haff0);
    put(6, 16'h0400);
    put(16'h1c, 16'h0100);
    put(16'h1d, 16'hbfff);
    go(16'h0014);
    chk(ack_cnt, 16'h0000);
    repeat (30) @(posedge sys_clk_i);
    chk(ack_cnt > 1, 16'h0001);
    chk(irq_id, 16'h0001);
    chk(mdl_u.dmem[16'h2fe], 16'h0000);
    chk(mdl_u.dmem[16'h2ff], 16'h001d);
    $display("interrupt test done");
  endtask
  // Store through the data window reaches I/O index 1; a direct read comes back
  task automatic t_iowin;
    setup();
    mdl_u.iomem[2] = 8'h4b;
    put(0, 16'h52a1);
    put(1, 16'h50b0);
    put(2, 16'h5707);
    put(3, 16'h8b00);
    put(4, 16'ha051);
    put(5, 16'ha871);
    put(6, 16'h0100);
    put(7, 16'h0200);
    put(8, 16'hbfff);
    go(16'h0009);
    chk(mdl_u.iomem[1], 16'h0077);
    chk(mdl_u.iomem[3], 16'h004b);
    chk(flags, 16'h0000);
    $display("io window test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Flag table covers add, subtract, and, or, eor, decrement at their edge values
  // Unary op takes its code from the low bits of r17's field, which select decrement
  initial begin
    t_alu(4'h1, 2'h0, 8'h0f, 8'h01, 8'h10, 8'h20);
    t_alu(4'h1, 2'h0, 8'h7f, 8'h01, 8'h80, 8'h2c);
    t_alu(4'h1, 2'h0, 8'h80, 8'h80, 8'h00, 8'h1b);
    t_alu(4'h1, 2'h2, 8'h10, 8'h01, 8'h0f, 8'h20);
    t_alu(4'h1, 2'h2, 8'h01, 8'h02, 8'hff, 8'h35);
    t_alu(4'h2, 2'h0, 8'hf0, 8'h0f, 8'h00, 8'h02);
    t_alu(4'h2, 2'h1, 8'hf0, 8'h0f, 8'hff, 8'h14);
    t_alu(4'h2, 2'h2, 8'h5a, 8'h5a, 8'h00, 8'h02);
    t_alu(4'h6, 2'h0, 8'h80, 8'h01, 8'h7f, 8'h18);
    t_bit();
    t_ldst();
    t_pstore();
    t_iowin();
    t_irq();
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
